//--- design/pp_cfg_pkg.sv
// constants and types for the parallel port configuration register bank
package pp_cfg_pkg;
  // ----------------------------------------------------------------
  // configuration space
  // ----------------------------------------------------------------
  localparam logic [7:0] CFG_IDX_PP = 8'hf0;
  localparam logic [7:0] CFG_RESET = 8'hf2;
  localparam logic [7:0] CFG_WMASK = 8'hf3;
  localparam int MODE_MSB = 7;
  localparam int MODE_LSB = 5;
  localparam int EXT_BIT = 4;
  localparam int CLK_BIT = 1;
  localparam int FLT_BIT = 0;
  // ----------------------------------------------------------------
  // runtime offsets
  // ----------------------------------------------------------------
  localparam logic [10:0] RT_EXT_INDEX = 11'h403;
  localparam logic [10:0] RT_EXT_DATA = 11'h404;
  localparam logic [10:0] RT_EXT_AUX = 11'h405;
  localparam logic [10:0] RT_CTRL = 11'h002;
  localparam logic [7:0] CTRL_SAFE = 8'hc4;
  localparam logic [7:0] SEC_IDX_CTRL2 = 8'h02;
  localparam int CTRL2_EPP19_BIT = 4;
  localparam int CTRL_DIR_BIT = 5;
  // ----------------------------------------------------------------
  // mode select encodings
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_STD = 3'h0,
    MODE_EXT = 3'h1,
    MODE_EPP17 = 3'h2,
    MODE_ECP = 3'h4,
    MODE_RSV5 = 3'h5,
    MODE_RSV6 = 3'h6,
    MODE_ECP_EPP = 3'h7
  } pp_mode_e;
  // decoded mode family, one-hot
  typedef enum logic [4:0] {
    FAM_STD = 5'h01,
    FAM_EXT = 5'h02,
    FAM_EPP = 5'h04,
    FAM_ECP = 5'h08,
    FAM_ECPE = 5'h10
  } pp_family_e;
endpackage : pp_cfg_pkg

//--- design/pp_ext_regs.sv
`timescale 1ns/100ps
// extended index/data/aux registers with a small second-level store
module pp_ext_regs #(
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // access
  input wire logic [1:0] sel_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] wdata_i,
  // results
  output logic [7:0] rdata_o,
  output logic [7:0] ctrl2_o
);
  import pp_cfg_pkg::*;

  typedef struct packed {
    logic [7:0] index;
    logic [7:0] aux;
    logic [DEPTH-1:0][7:0] mem;
    logic [7:0] rdata;
  } ext_s;

  ext_s st_q;
  ext_s st_d;
  logic [$clog2(DEPTH)-1:0] wa;

  // ----------------------------------------------------------------
  // index, data and aux access
  // ----------------------------------------------------------------
  // index wraps into the store; upper index bits are kept for readback
  always_comb begin
    st_d = st_q;
    wa = st_q.index[$clog2(DEPTH)-1:0];
    if (wr_i) begin
      case (sel_i)
        2'h0: st_d.index = wdata_i;
        2'h1: st_d.mem[wa] = wdata_i;
        2'h2: st_d.aux = wdata_i;
        default: st_d.aux = st_q.aux;
      endcase
    end
    if (rd_i) begin
      case (sel_i)
        2'h0: st_d.rdata = st_q.index;
        2'h1: st_d.rdata = st_q.mem[wa];
        2'h2: st_d.rdata = st_q.aux;
        default: st_d.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign rdata_o = st_q.rdata;
  assign ctrl2_o = st_q.mem[SEC_IDX_CTRL2[$clog2(DEPTH)-1:0]];
endmodule : pp_ext_regs

//--- design/pp_mode_decode.sv
`timescale 1ns/100ps
// decode of the mode select field into a one-hot mode family
module pp_mode_decode (
  // field in
  input wire logic [2:0] mode_i,
  // decoded
  output logic [4:0] family_o,
  output logic reserved_o
);
  import pp_cfg_pkg::*;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  // reserved codes fall back to the standard family so pins stay sane
  always_comb begin
    reserved_o = 1'b0;
    case (mode_i)
      MODE_STD: family_o = FAM_STD;
      MODE_EXT: family_o = FAM_EXT;
      MODE_EPP17: family_o = FAM_EPP;
      MODE_ECP: family_o = FAM_ECP;
      MODE_ECP_EPP: family_o = FAM_ECPE;
      default: begin
        family_o = FAM_STD;
        reserved_o = 1'b1;
      end
    endcase
  end
endmodule : pp_mode_decode

//--- design/pp_cfg_regs.sv
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/100ps
// parallel port configuration register and the controls it drives

// Functional notes
// - mode 000 standard, 010 epp 1.7
// - mode 001 software-directed data direction
// - mode 100 ecp, no epp mode 4
// - mode 111 ecp with epp; 101/110 reserved
// - mode 4 epp revision from extended control bit4
// - bit4 clear ignores extended registers
// - bit4 set makes extended registers reachable
// - bit1 clear stops port clock while active, keeps registers
// - bit1 set runs port clock
// - bit0 set floats outputs when inactive
// - 403h/404h/405h are index, data, aux
module pp_cfg_regs (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // configuration space port
  input wire logic [7:0] cfg_addr_i,
  input wire logic [7:0] cfg_wdata_i,
  input wire logic cfg_wr_i,
  input wire logic cfg_rd_i,
  output logic [7:0] cfg_rdata_o,
  // logical device activation
  input wire logic dev_active_i,
  // runtime port space
  input wire logic [10:0] rt_addr_i,
  input wire logic [7:0] rt_wdata_i,
  input wire logic rt_wr_i,
  input wire logic rt_rd_i,
  output logic [7:0] rt_rdata_o,
  output logic rt_hit_o,
  // mode outputs to the port engines
  output logic [4:0] mode_family_o,
  output logic mode_reserved_o,
  output logic epp_rev19_o,
  output logic data_dir_in_o,
  output logic port_clk_en_o,
  output logic pins_float_o,
  output logic mode_unsafe_o
);
  import pp_cfg_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] cfg;
    logic [7:0] cfg_rdata;
    logic [7:0] ctrl;
    logic [7:0] rt_rdata;
    logic ext_rd_pend;
    logic rt_hit;
    logic [4:0] family;
    logic reserved;
    logic epp19;
    logic dir_in;
    logic clk_en;
    logic pins_float;
    logic unsafe;
  } cfg_s;

  cfg_s st_q;
  cfg_s st_d;

  logic [4:0] fam_c;
  logic rsv_c;
  logic [7:0] ext_rdata;
  logic [7:0] ctrl2;
  logic [1:0] ext_sel;
  logic ext_hit;
  logic ext_wr;
  logic ext_rd;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // one decode of the extended window used for both strobes
  function automatic logic ext_window(input logic [10:0] a);
    ext_window = (a == RT_EXT_INDEX) || (a == RT_EXT_DATA) ||
      (a == RT_EXT_AUX);
  endfunction : ext_window

  // selector within the extended window
  function automatic logic [1:0] ext_slot(input logic [10:0] a);
    logic [10:0] d;
    d = a - RT_EXT_INDEX;
    ext_slot = d[1:0];
  endfunction : ext_slot

  // ----------------------------------------------------------------
  // extended access gating
  // ----------------------------------------------------------------
  // a cleared bit4 hides the window entirely: no store, no readback
  assign ext_hit = ext_window(rt_addr_i) && st_q.cfg[EXT_BIT];
  assign ext_wr = rt_wr_i && ext_hit;
  assign ext_rd = rt_rd_i && ext_hit;
  assign ext_sel = ext_slot(rt_addr_i);

  pp_ext_regs #(
    .DEPTH(8)
  ) u_ext (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .sel_i(ext_sel),
    .wr_i(ext_wr),
    .rd_i(ext_rd),
    .wdata_i(rt_wdata_i),
    .rdata_o(ext_rdata),
    .ctrl2_o(ctrl2)
  );

  pp_mode_decode u_dec (
    .mode_i(st_q.cfg[MODE_MSB:MODE_LSB]),
    .family_o(fam_c),
    .reserved_o(rsv_c)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    // configuration write; reserved bits masked away
    if (cfg_wr_i && (cfg_addr_i == CFG_IDX_PP)) begin
      st_d.cfg = cfg_wdata_i & CFG_WMASK;
    end
    // configuration read, unmapped index reads zero
    if (cfg_rd_i) begin
      if (cfg_addr_i == CFG_IDX_PP) begin
        st_d.cfg_rdata = st_q.cfg & CFG_WMASK;
      end else begin
        st_d.cfg_rdata = 8'h00;
      end
    end
    // control register copy, watched for the safe value
    if (rt_wr_i && (rt_addr_i == RT_CTRL)) begin
      st_d.ctrl = rt_wdata_i;
    end
    // extended read data arrives from the store one cycle later
    st_d.ext_rd_pend = ext_rd;
    st_d.rt_hit = ext_rd;
    if (rt_rd_i && !ext_hit) begin
      st_d.rt_rdata = 8'h00;
    end
    // register the decoded controls so outputs come from flops
    st_d.family = fam_c;
    st_d.reserved = rsv_c;
    // epp revision only meaningful in ecp mode 4 capable setting
    st_d.epp19 = (fam_c == FAM_ECPE) && ctrl2[CTRL2_EPP19_BIT];
    // direction: standard always drives, extended uses control bit
    st_d.dir_in = (fam_c == FAM_EXT) && st_q.ctrl[CTRL_DIR_BIT];
    // clock runs unless stopped while active; state is never cleared
    st_d.clk_en = st_q.cfg[CLK_BIT] || !dev_active_i;
    // float only while inactive and enabled
    st_d.pins_float = st_q.cfg[FLT_BIT] && !dev_active_i;
    // flags a mode change written while inactive or without the safe control value
    if (cfg_wr_i && (cfg_addr_i == CFG_IDX_PP)) begin
      st_d.unsafe = (cfg_wdata_i[MODE_MSB:MODE_LSB] !=
        st_q.cfg[MODE_MSB:MODE_LSB]) &&
        (!dev_active_i || (st_q.ctrl != CTRL_SAFE));
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      st_q <= '0;
      st_q.cfg <= CFG_RESET;
      st_q.clk_en <= 1'b1;
      st_q.family <= FAM_ECPE;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // extended read data come out of the store's own register
  assign rt_rdata_o = st_q.ext_rd_pend ? ext_rdata : st_q.rt_rdata;
  assign rt_hit_o = st_q.rt_hit;
  assign cfg_rdata_o = st_q.cfg_rdata;
  assign mode_family_o = st_q.family;
  assign mode_reserved_o = st_q.reserved;
  assign epp_rev19_o = st_q.epp19;
  assign data_dir_in_o = st_q.dir_in;
  assign port_clk_en_o = st_q.clk_en;
  assign pins_float_o = st_q.pins_float;
  assign mode_unsafe_o = st_q.unsafe;
endmodule : pp_cfg_regs

//--- verif/pp_cfg_chk.sv
// assertion checker for the parallel port configuration bank
`timescale 1ns/100ps
module pp_cfg_chk
  import pp_cfg_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // configuration port
  input wire logic [7:0] cfg_addr_i,
  input wire logic [7:0] cfg_wdata_i,
  input wire logic cfg_wr_i,
  input wire logic cfg_rd_i,
  input wire logic [7:0] cfg_rdata_o,
  input wire logic dev_active_i,
  // runtime port
  input wire logic [10:0] rt_addr_i,
  input wire logic rt_rd_i,
  input wire logic [7:0] rt_rdata_o,
  input wire logic rt_hit_o,
  // controls
  input wire logic [4:0] mode_family_o,
  input wire logic mode_reserved_o,
  input wire logic epp_rev19_o,
  input wire logic port_clk_en_o,
  input wire logic pins_float_o
);
  logic [7:0] m_q;
  logic win;
  // shadow copy, masked so reserved bits stay clear
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) m_q <= CFG_RESET;
    else if (cfg_wr_i && cfg_addr_i == CFG_IDX_PP)
      m_q <= cfg_wdata_i & CFG_WMASK;
  end
  // extended window decode
  assign win = rt_addr_i inside {[RT_EXT_INDEX:RT_EXT_AUX]};
  // mode 011 is undocumented; it decodes as standard and is flagged reserved
  function automatic logic [4:0] fam(input logic [2:0] m);
    case (m)
      3'h1: return FAM_EXT;
      3'h2: return FAM_EPP;
      3'h4: return FAM_ECP;
      3'h7: return FAM_ECPE;
      default: return FAM_STD;
    endcase
  endfunction : fam
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  rd_data_a: assert property (
    cfg_rd_i && cfg_addr_i == CFG_IDX_PP |=> cfg_rdata_o == m_q)
    else $error("config read data wrong");
  unmapped_rd_a: assert property (
    cfg_rd_i && cfg_addr_i != CFG_IDX_PP |=> cfg_rdata_o == 8'h00)
    else $error("unmapped index read not zero");
  mode_fam_a: assert property (
    mode_family_o == fam($past(m_q[7:5])))
    else $error("mode family wrong");
  mode_rsv_a: assert property (
    mode_reserved_o == ($past(m_q[7:5]) inside {3'h3, 3'h5, 3'h6}))
    else $error("reserved mode flag wrong");
  epp_rev_a: assert property (
    epp_rev19_o |-> $past(m_q[7:5]) == 3'h7)
    else $error("epp revision outside ecp mode 4");
  clk_en_a: assert property (
    port_clk_en_o == !$past(!m_q[CLK_BIT] && dev_active_i))
    else $error("port clock enable wrong");
  pin_float_a: assert property (
    pins_float_o == $past(m_q[FLT_BIT] && !dev_active_i))
    else $error("pin float wrong");
  ext_off_a: assert property (
    rt_rd_i && win && !m_q[EXT_BIT] |=> rt_rdata_o == 8'h00 && !rt_hit_o)
    else $error("extended read not ignored");
  ext_hit_a: assert property (
    rt_rd_i && win && m_q[EXT_BIT] |=> rt_hit_o)
    else $error("extended read not taken");
endmodule : pp_cfg_chk
bind pp_cfg_regs pp_cfg_chk u_chk (.*);

//--- verif/testbench.sv
// self-checking bench for the parallel port configuration bank
`timescale 1ns/100ps
module testbench;
  import pp_cfg_pkg::*;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] cfg_addr_i = 8'h00, cfg_wdata_i = 8'h00, cfg_rdata_o, rd;
  logic cfg_wr_i = 1'b0, cfg_rd_i = 1'b0, dev_active_i = 1'b1;
  logic [10:0] rt_addr_i = 11'h000;
  logic [7:0] rt_wdata_i = 8'h00, rt_rdata_o;
  logic rt_wr_i = 1'b0, rt_rd_i = 1'b0, rt_hit_o;
  logic [4:0] mode_family_o;
  logic mode_reserved_o, epp_rev19_o, data_dir_in_o;
  logic port_clk_en_o, pins_float_o, mode_unsafe_o;
  int num_errors = 0, tests_run = 0;
  pp_cfg_regs DUT (.*);
  // ----
  // bus tasks
  // ----
  // wide enough for the joined data and hit compare
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // one strobe cycle; read data taken in the cycle after the strobe
  task automatic bus(input bit rt, input bit wr, input logic [10:0] a,
                     input logic [7:0] d);
    @(posedge core_clk_i);
    cfg_addr_i <= a[7:0];
    rt_addr_i <= a;
    cfg_wdata_i <= d;
    rt_wdata_i <= d;
    {cfg_wr_i, cfg_rd_i} <= {!rt && wr, !rt && !wr};
    {rt_wr_i, rt_rd_i} <= {rt && wr, rt && !wr};
    @(posedge core_clk_i);
    {cfg_wr_i, cfg_rd_i, rt_wr_i, rt_rd_i} <= 4'h0;
    #1 rd = rt ? rt_rdata_o : cfg_rdata_o;
  endtask : bus
  // derived outputs lag the register by one cycle
  task automatic st();
    @(posedge core_clk_i);
    #1;
  endtask : st
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize
  // ----
  // scenarios
  // ----
  task automatic t_reset();
    bus(0, 0, 11'h0f0, 8'h00);
    check(rd, 8'hf2);
    check(mode_family_o, 5'h10);
    check({port_clk_en_o, pins_float_o}, 2'b10);
    bus(0, 1, 11'h0f0, 8'hff);
    bus(0, 1, 11'h030, 8'h00);
    bus(0, 0, 11'h030, 8'h00);
    check(rd, 8'h00);
    bus(0, 0, 11'h0f0, 8'h00);
    check(rd, 8'hf3);
    $display("reset and reserved bits done");
  endtask : t_reset
  task automatic t_modes();
    logic [2:0] m [8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
    logic [4:0] f [8] = '{5'h01, 5'h02, 5'h04, 5'h01, 5'h08, 5'h01, 5'h01,
                          5'h10};
    bus(1, 1, 11'h002, 8'hc4);
    for (int i = 0; i < 8; i++) begin
      bus(0, 1, 11'h0f0, {m[i], 5'h12});
      st();
      check(mode_family_o, f[i]);
      // 011 is undocumented and is flagged like the reserved codes
      check(mode_reserved_o, m[i] inside {3'h3, 3'h5, 3'h6});
      check(mode_unsafe_o, 1'b0);
    end
    $display("mode select done");
  endtask : t_modes
  task automatic t_ext();
    bus(0, 1, 11'h0f0, 8'hf2);
    bus(1, 1, 11'h403, 8'h02);
    bus(1, 1, 11'h404, 8'h10);
    bus(1, 0, 11'h404, 8'h00);
    check(rd, 8'h10);
    check({rt_hit_o, epp_rev19_o}, 2'b11);
    bus(1, 1, 11'h405, 8'h5a);
    bus(1, 0, 11'h405, 8'h00);
    check(rd, 8'h5a);
    bus(1, 0, 11'h403, 8'h00);
    check(rd, 8'h02);
    bus(0, 1, 11'h0f0, 8'he2);
    bus(1, 1, 11'h404, 8'h00);
    bus(1, 0, 11'h404, 8'h00);
    check({rd, rt_hit_o}, 9'h000);
    check(epp_rev19_o, 1'b1);
    bus(0, 1, 11'h0f0, 8'h92);
    st();
    check(epp_rev19_o, 1'b0);
    bus(1, 0, 11'h404, 8'h00);
    check(rd, 8'h10);
    $display("extended registers done");
  endtask : t_ext
  task automatic t_dir_pwr();
    bus(0, 1, 11'h0f0, 8'h32);
    bus(1, 1, 11'h002, 8'h20);
    st();
    check(data_dir_in_o, 1'b1);
    bus(0, 1, 11'h0f0, 8'h12);
    st();
    check({data_dir_in_o, mode_unsafe_o}, 2'b01);
    bus(1, 1, 11'h002, 8'hc4);
    bus(0, 1, 11'h0f0, 8'hf1);
    st();
    check(port_clk_en_o, 1'b0);
    bus(0, 0, 11'h0f0, 8'h00);
    check(rd, 8'hf1);
    // activation changes on the edge like every other input
    @(posedge core_clk_i);
    dev_active_i <= 1'b0;
    st();
    check({port_clk_en_o, pins_float_o}, 2'b11);
    // a mode change while inactive breaks the host's preparation
    bus(0, 1, 11'h0f0, 8'h11);
    st();
    check(mode_unsafe_o, 1'b1);
    @(posedge core_clk_i);
    dev_active_i <= 1'b1;
    st();
    check(pins_float_o, 1'b0);
    $display("direction and power done");
  endtask : t_dir_pwr
  // ----
  // clock and main sequence
  // ----
  initial begin
    forever #10 core_clk_i = ~core_clk_i;
  end
  initial begin
    repeat (3) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_modes();
    t_ext();
    t_dir_pwr();
    summarize();
  end
endmodule : testbench
